/* File: logic/dhi_regs.vh */
// Constants for the display host interface
`ifndef DHI_REGS_VH
`define DHI_REGS_VH

// Interface mode codes on {iface_sel_b, iface_sel_a}
`define DHI_MODE_SERIAL     2'h0
`define DHI_MODE_I2C        2'h1
`define DHI_MODE_SEP_STROBE 2'h2
`define DHI_MODE_EN_STROBE  2'h3

// Data line positions used by the serial modes
`define DHI_SCLK_BIT   0
`define DHI_SERIAL_DATA_INPUT_BIT   1
`define DHI_I2C_DATA_OUT_PIN_BIT 2

// Width, positions and reset value of the synchronised pin vector
`define DHI_PIN_W      15
`define DHI_PIN_INIT   14
`define DHI_PIN_SEL_B  13
`define DHI_PIN_SEL_A  12
`define DHI_PIN_CS     11
`define DHI_PIN_DC     10
`define DHI_PIN_RW     9
`define DHI_PIN_EN     8
`define DHI_PIN_RST    15'h7FFF

// Serial byte framing
`define DHI_LAST_BIT   3'h7
`define DHI_BYTE_BITS  4'h8

// I2C control byte fields
`define DHI_CTRL_CO    7
`define DHI_CTRL_DC    6

// Upper six bits of the I2C slave address; value is arbitrary
`define DHI_I2C_ADDR_HI 6'h2A

`endif

/* File: logic/dhi_sync.v */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module dhi_sync #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_reg;

    always @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* File: logic/dhi_i2c.v */
// I2C write-only slave that delivers control-tagged bytes
`timescale 1ns/1ps
`include "dhi_regs.vh"
module dhi_i2c #(
    parameter [5:0] ADDR_HI = `DHI_I2C_ADDR_HI
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       en,
    input  wire       addr_lsb,
    input  wire       scl,
    input  wire       sda,
    output reg        sda_low_reg,
    output reg        byte_valid_reg,
    output reg  [7:0] byte_reg,
    output reg        is_data_reg
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_ADDR = 5'h02;
    localparam [4:0] S_CTRL = 5'h04;
    localparam [4:0] S_DATA = 5'h08;
    localparam [4:0] S_ACK  = 5'h10;

    reg [4:0] state_reg;
    reg [4:0] ret_reg;
    reg [7:0] sh_reg;
    reg [3:0] cnt_reg;
    reg       scl_d_reg;
    reg       sda_d_reg;
    reg       co_reg;
    reg       dc_reg;

    wire scl_rise = scl & ~scl_d_reg;
    wire scl_fall = ~scl & scl_d_reg;
    wire start    = scl & scl_d_reg & sda_d_reg & ~sda;
    wire stop     = scl & scl_d_reg & ~sda_d_reg & sda;

    always @(posedge clk) begin
        if (!rstn) begin
            state_reg      <= S_IDLE;
            ret_reg        <= S_IDLE;
            sh_reg         <= 8'h00;
            cnt_reg        <= 4'h0;
            scl_d_reg      <= 1'b1;
            sda_d_reg      <= 1'b1;
            co_reg         <= 1'b0;
            dc_reg         <= 1'b0;
            sda_low_reg    <= 1'b0;
            byte_valid_reg <= 1'b0;
            byte_reg       <= 8'h00;
            is_data_reg    <= 1'b0;
        end else begin
            scl_d_reg      <= scl;
            sda_d_reg      <= sda;
            byte_valid_reg <= 1'b0;
            if (!en) begin
                state_reg   <= S_IDLE;
                cnt_reg     <= 4'h0;
                sda_low_reg <= 1'b0;
            end else if (start) begin
                state_reg   <= S_ADDR;
                cnt_reg     <= 4'h0;
                sda_low_reg <= 1'b0;
            end else if (stop) begin
                state_reg   <= S_IDLE;
                sda_low_reg <= 1'b0;
            end else begin
                case (state_reg)
                    S_ADDR, S_CTRL, S_DATA: begin
                        if (scl_rise) begin
                            sh_reg  <= {sh_reg[6:0], sda};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == `DHI_BYTE_BITS) begin
                            cnt_reg     <= 4'h0;
                            state_reg   <= S_ACK;
                            sda_low_reg <= 1'b1;
                            if (state_reg == S_ADDR) begin
                                // D/C select pin level is the address low bit
                                if (sh_reg[7:1] == {ADDR_HI, addr_lsb} && !sh_reg[0]) begin
                                    ret_reg <= S_CTRL;
                                end else begin
                                    state_reg   <= S_IDLE;
                                    sda_low_reg <= 1'b0;
                                end
                            end else if (state_reg == S_CTRL) begin
                                co_reg  <= sh_reg[`DHI_CTRL_CO];
                                dc_reg  <= sh_reg[`DHI_CTRL_DC];
                                ret_reg <= S_DATA;
                            end else begin
                                byte_reg       <= sh_reg;
                                is_data_reg    <= dc_reg;
                                byte_valid_reg <= 1'b1;
                                ret_reg        <= co_reg ? S_CTRL : S_DATA;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            sda_low_reg <= 1'b0;
                            state_reg   <= ret_reg;
                        end
                    end
                    S_IDLE: begin
                        cnt_reg <= 4'h0;
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: logic/dhi_host_if.v */
// Display controller host port: parallel, serial and I2C byte receiver
`timescale 1ns/1ps
`include "dhi_regs.vh"
module dhi_host_if #(
    parameter [5:0] I2C_ADDR_HI = `DHI_I2C_ADDR_HI
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       init_pin_low_n,
    input  wire       iface_sel_a,
    input  wire       iface_sel_b,
    input  wire       cs_n,
    input  wire       dc_sel,
    input  wire       rw_wr_n,
    input  wire       en_rd_n,
    input  wire [7:0] host_data_in,
    output reg  [7:0] host_data_out,
    output reg  [7:0] host_data_oe,
    input  wire [7:0] rd_data,
    output reg        rd_req,
    output reg        rx_valid,
    output reg  [7:0] rx_byte,
    output reg        rx_is_data,
    output reg        rx_drop
);
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WR   = 3'h2;
    localparam [2:0] ST_RD   = 3'h4;

    function par_mode;
        input [1:0] m;
        begin
            par_mode = (m == `DHI_MODE_EN_STROBE) || (m == `DHI_MODE_SEP_STROBE);
        end
    endfunction

    wire [`DHI_PIN_W-1:0] pin_s;
    reg  [`DHI_PIN_W-1:0] pin_d_reg;
    reg  [2:0]            state_reg;
    reg  [2:0]            state_next;
    reg                   acc_dc_reg;
    reg  [7:0]            sh_reg;
    reg  [2:0]            bit_cnt_reg;
    reg                   wr_done;
    reg                   rd_go;

    // All pins cross two flops before any logic looks at them
    dhi_sync #(
        .W       (`DHI_PIN_W),
        .RST_VAL (`DHI_PIN_RST)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({init_pin_low_n, iface_sel_b, iface_sel_a, cs_n,
                dc_sel, rw_wr_n, en_rd_n, host_data_in}),
        .q    (pin_s)
    );

    wire       core_rstn = rstn & pin_s[`DHI_PIN_INIT];
    wire [1:0] mode      = {pin_s[`DHI_PIN_SEL_B], pin_s[`DHI_PIN_SEL_A]};
    wire       cs_act    = ~pin_s[`DHI_PIN_CS];
    wire       cs_rise   = pin_s[`DHI_PIN_CS] & ~pin_d_reg[`DHI_PIN_CS];
    wire       dc_s      = pin_s[`DHI_PIN_DC];
    wire       rw_s      = pin_s[`DHI_PIN_RW];
    wire       rw_rise   = rw_s & ~pin_d_reg[`DHI_PIN_RW];
    wire       rw_fall   = ~rw_s & pin_d_reg[`DHI_PIN_RW];
    wire       en_rise   = pin_s[`DHI_PIN_EN] & ~pin_d_reg[`DHI_PIN_EN];
    wire       en_fall   = ~pin_s[`DHI_PIN_EN] & pin_d_reg[`DHI_PIN_EN];
    wire [7:0] data_s    = pin_s[7:0];
    wire       sclk_rise = pin_s[`DHI_SCLK_BIT] & ~pin_d_reg[`DHI_SCLK_BIT];
    wire       serial_data_input_s    = pin_s[`DHI_SERIAL_DATA_INPUT_BIT];
    wire       is_en     = (mode == `DHI_MODE_EN_STROBE);
    wire       par_on    = par_mode(mode) & cs_act;
    wire       ser_on    = (mode == `DHI_MODE_SERIAL) & cs_act;
    wire       i2c_on    = (mode == `DHI_MODE_I2C) & cs_act;
    wire       wr_end    = is_en ? en_fall : rw_rise;
    wire       rd_end    = is_en ? en_fall : en_rise;

    wire       i2c_sda_low;
    wire       i2c_valid;
    wire [7:0] i2c_byte;
    wire       i2c_is_data;

    // I2C: clock on line zero, data in on line one, ack out on line two
    dhi_i2c #(
        .ADDR_HI (I2C_ADDR_HI)
    ) u_i2c (
        .clk            (clk),
        .rstn           (core_rstn),
        .en             (i2c_on),
        .addr_lsb       (dc_s),
        .scl            (pin_s[`DHI_SCLK_BIT]),
        .sda            (pin_s[`DHI_SERIAL_DATA_INPUT_BIT]),
        .sda_low_reg    (i2c_sda_low),
        .byte_valid_reg (i2c_valid),
        .byte_reg       (i2c_byte),
        .is_data_reg    (i2c_is_data)
    );

    // Previous pin levels for edge detection; no reset of its own, follows pin_s every cycle
    always @(posedge clk) begin
        pin_d_reg <= pin_s;
    end

    // Parallel access sequencing
    always @* begin
        state_next = state_reg;
        wr_done    = 1'b0;
        rd_go      = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (par_on) begin
                    if (is_en) begin
                        if (en_rise) begin
                            state_next = rw_s ? ST_RD : ST_WR;
                            rd_go      = rw_s;
                        end
                    end else if (rw_fall) begin
                        state_next = ST_WR;
                    end else if (en_fall) begin
                        state_next = ST_RD;
                        rd_go      = 1'b1;
                    end
                end
            end
            ST_WR: begin
                if (!par_mode(mode)) begin
                    state_next = ST_IDLE;
                end else if (!cs_act || wr_end) begin
                    state_next = ST_IDLE;
                    wr_done    = 1'b1;
                end
            end
            ST_RD: begin
                if (!par_on || cs_rise || rd_end) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!core_rstn) begin
            state_reg     <= ST_IDLE;
            acc_dc_reg    <= 1'b0;
            sh_reg        <= 8'h00;
            bit_cnt_reg   <= 3'h0;
            host_data_out <= 8'h00;
            host_data_oe  <= 8'h00;
            rd_req        <= 1'b0;
            rx_valid      <= 1'b0;
            rx_byte       <= 8'h00;
            rx_is_data    <= 1'b0;
            rx_drop       <= 1'b0;
        end else begin
            state_reg <= state_next;
            rd_req    <= rd_go;
            rx_valid  <= 1'b0;
            rx_drop   <= 1'b0;

            if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
                acc_dc_reg <= dc_s;
            end
            if (wr_done) begin
                rx_valid   <= 1'b1;
                rx_byte    <= data_s;
                rx_is_data <= acc_dc_reg;
            end

            // Serial shift in, partial byte dropped when select rises
            if (ser_on) begin
                if (sclk_rise) begin
                    sh_reg      <= {sh_reg[6:0], serial_data_input_s};
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == `DHI_LAST_BIT) begin
                        rx_valid   <= 1'b1;
                        rx_byte    <= {sh_reg[6:0], serial_data_input_s};
                        rx_is_data <= dc_s;
                    end
                end
            end else begin
                if (bit_cnt_reg != 3'h0) begin
                    rx_drop <= 1'b1;
                end
                bit_cnt_reg <= 3'h0;
                sh_reg      <= 8'h00;
            end

            if (i2c_valid) begin
                rx_valid   <= 1'b1;
                rx_byte    <= i2c_byte;
                rx_is_data <= i2c_is_data;
            end

            // Bus drive: whole byte on parallel reads, ack bit in I2C
            if (mode == `DHI_MODE_I2C) begin
                host_data_out <= 8'h00;
                host_data_oe  <= i2c_sda_low ? (8'h01 << `DHI_I2C_DATA_OUT_PIN_BIT) : 8'h00;
            end else if (state_next == ST_RD) begin
                if (rd_go) begin
                    host_data_out <= rd_data;
                end
                host_data_oe <= 8'hFF;
            end else begin
                host_data_oe <= 8'h00;
            end
        end
    end
endmodule

/* File: testbench/dhi_host_if_sva.sv */
// Assertions on the display host port outputs
`timescale 1ns/1ps
module dhi_host_if_sva (
    input wire       clk,
    input wire       rstn,
    input wire       init_pin_low_n,
    input wire       iface_sel_b,
    input wire       cs_n,
    input wire [7:0] host_data_out,
    input wire [7:0] host_data_oe,
    input wire       rd_req,
    input wire       rx_valid,
    input wire [7:0] rx_byte,
    input wire       rx_is_data,
    input wire       rx_drop
);
    reg [2:0] cs_hi_cnt;
    reg [2:0] init_hi_cnt;
    // Saturating counts of cycles with select high and init pin released
    always @(posedge clk) begin
        if (!rstn) begin
            cs_hi_cnt   <= 3'h0;
            init_hi_cnt <= 3'h0;
        end else begin
            cs_hi_cnt   <= cs_n ? cs_hi_cnt + {2'h0, cs_hi_cnt != 3'h7} : 3'h0;
            init_hi_cnt <= init_pin_low_n ? init_hi_cnt + {2'h0, init_hi_cnt != 3'h7} : 3'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_rd_drive;
        ##[0:3] (host_data_oe == 8'hFF);
    endsequence
    sequence s_init_held;
        !init_pin_low_n [*5];
    endsequence
    a_rx_one_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
    a_rx_byte_held: assert property ((!rx_valid && init_hi_cnt == 3'h7) |->
        $stable({rx_byte, rx_is_data})) else $error("rx byte changed without rx_valid");
    a_drop_pulse: assert property (rx_drop |=> !rx_drop)
        else $error("rx_drop longer than one cycle");
    a_rdreq_parallel: assert property (rd_req |-> iface_sel_b)
        else $error("read request outside parallel modes");
    a_read_drives_bus: assert property (rd_req |-> s_rd_drive)
        else $error("read did not drive the bus");
    a_oe_shape: assert property (host_data_oe == 8'h00 || host_data_oe == 8'hFF ||
        host_data_oe == 8'h04) else $error("partial bus drive");
    a_idle_no_drive: assert property (cs_hi_cnt == 3'h7 |-> host_data_oe == 8'h00)
        else $error("bus driven with chip select high");
    a_ack_pulls_low: assert property (host_data_oe == 8'h04 |-> !host_data_out[2])
        else $error("acknowledge not low");
    a_reset_quiet: assert property ($rose(rstn) |-> host_data_oe == 8'h00 && !rx_valid)
        else $error("outputs active after reset");
    a_init_quiet: assert property (s_init_held |-> host_data_oe == 8'h00 && !rx_valid)
        else $error("outputs active under init pin");
endmodule
bind dhi_host_if dhi_host_if_sva u_sva (.clk(clk), .rstn(rstn),
    .init_pin_low_n(init_pin_low_n), .iface_sel_b(iface_sel_b), .cs_n(cs_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .rd_req(rd_req),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_is_data(rx_is_data), .rx_drop(rx_drop));

/* File: testbench/dhi_host_model.sv */
// Host processor model driving the display host port pins
`timescale 1ns/1ps
module dhi_host_model (
    input  wire       clk,
    input  wire [7:0] host_data_out,
    input  wire [7:0] host_data_oe,
    output reg        init_pin_low_n,
    output reg        iface_sel_a,
    output reg        iface_sel_b,
    output reg        cs_n,
    output reg        dc_sel,
    output reg        rw_wr_n,
    output reg        en_rd_n,
    output wire [7:0] host_data_in
);
    reg  [7:0] drv;
    reg        sda_low;
    // I2C data line is open drain with pull-up, D1 and D2 tied together
    wire       sda = ~(sda_low | (host_data_oe[2] & ~host_data_out[2]));
    assign host_data_in = (iface_sel_a & ~iface_sel_b) ? {5'h1F, sda, sda, drv[0]} :
                          (host_data_oe & host_data_out) | (~host_data_oe & drv);
    initial begin
        {init_pin_low_n, iface_sel_b, iface_sel_a, cs_n} = 4'hF;
        {dc_sel, rw_wr_n, en_rd_n, sda_low} = 4'h0;
        drv = 8'h00;
    end
    task go(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task set_mode(input [1:0] m);
        go(1);
        {iface_sel_b, iface_sel_a} <= m;
        {rw_wr_n, en_rd_n} <= {2{m == 2'h2}};
        cs_n <= 1'b1;
        drv <= {7'h00, m == 2'h1};
        go(6);
    endtask
    task par_wr(input c, input dc, input [7:0] d);
        go(1);
        cs_n <= c;
        dc_sel <= dc;
        drv <= d;
        if (iface_sel_a) begin
            rw_wr_n <= 1'b0;
            go(2);
            en_rd_n <= 1'b1;
            go(4);
            en_rd_n <= 1'b0;
        end else begin
            go(2);
            rw_wr_n <= 1'b0;
            go(4);
            rw_wr_n <= 1'b1;
        end
        go(2);
        cs_n <= 1'b1;
        drv <= ~d;
        go(6);
    endtask
    task par_rd(output [7:0] q);
        go(1);
        cs_n <= 1'b0;
        drv <= ~drv;
        if (iface_sel_a) rw_wr_n <= 1'b1;
        go(2);
        en_rd_n <= ~en_rd_n;
        go(6);
        q = host_data_in;
        en_rd_n <= ~en_rd_n;
        go(2);
        cs_n <= 1'b1;
        go(6);
    endtask
    task ser(input dc, input [7:0] d, input integer n, input keep);
        integer i;
        go(1);
        cs_n <= 1'b0;
        dc_sel <= dc;
        for (i = 0; i < n; i++) begin
            drv[1] <= d[7-i];
            go(4);
            drv[0] <= 1'b1;
            go(4);
            drv[0] <= 1'b0;
        end
        go(4);
        if (!keep) cs_n <= 1'b1;
        go(6);
    endtask
    task pulse_init;
        go(1);
        init_pin_low_n <= 1'b0;
        go(6);
        init_pin_low_n <= 1'b1;
        go(4);
    endtask
    task i2c_bit(input b);
        sda_low <= ~b;
        go(2);
        drv[0] <= 1'b1;
        go(4);
        drv[0] <= 1'b0;
        go(2);
    endtask
    task i2c_byte(input [7:0] d, output ack);
        integer i;
        for (i = 7; i >= 0; i--) i2c_bit(d[i]);
        sda_low <= 1'b0;
        go(2);
        drv[0] <= 1'b1;
        go(2);
        ack = ~sda;
        go(2);
        drv[0] <= 1'b0;
        go(2);
    endtask
    task i2c_start(input a0);
        go(1);
        {cs_n, dc_sel, sda_low} <= {1'b0, a0, 1'b1};
        go(4);
        drv[0] <= 1'b0;
        go(2);
    endtask
    task i2c_stop;
        sda_low <= 1'b1;
        go(2);
        drv[0] <= 1'b1;
        go(4);
        sda_low <= 1'b0;
        go(6);
    endtask
endmodule

/* File: testbench/display_host_interface_bench.sv */
// Self-checking bench for the display host port
`timescale 1ns/1ps
`include "dhi_regs.vh"
module display_host_interface_bench;
    reg        clk;
    reg        rstn;
    reg  [7:0] rd_data;
    reg  [7:0] q;
    reg        ack;
    reg  [7:0] rx_last;
    reg        dc_last;
    integer    num_errors, samples_checked, rx_cnt, drop_cnt, rd_cnt, n, m;
    wire [7:0] host_data_in, host_data_out, host_data_oe, rx_byte;
    wire       init_pin_low_n, iface_sel_a, iface_sel_b, cs_n, dc_sel, rw_wr_n, en_rd_n;
    wire       rd_req, rx_valid, rx_is_data, rx_drop;
    dhi_host_if dut (.clk(clk), .rstn(rstn), .init_pin_low_n(init_pin_low_n),
        .iface_sel_a(iface_sel_a), .iface_sel_b(iface_sel_b), .cs_n(cs_n), .dc_sel(dc_sel),
        .rw_wr_n(rw_wr_n), .en_rd_n(en_rd_n), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe), .rd_data(rd_data),
        .rd_req(rd_req), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
        .rx_drop(rx_drop));
    dhi_host_model host (.clk(clk), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .init_pin_low_n(init_pin_low_n),
        .iface_sel_a(iface_sel_a), .iface_sel_b(iface_sel_b), .cs_n(cs_n), .dc_sel(dc_sel),
        .rw_wr_n(rw_wr_n), .en_rd_n(en_rd_n), .host_data_in(host_data_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            {dc_last, rx_last} <= {rx_is_data, rx_byte};
        end
        if (rx_drop === 1'b1) drop_cnt <= drop_cnt + 1;
        if (rd_req === 1'b1) rd_cnt <= rd_cnt + 1;
    end
    task check(input [15:0] seen, input [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_par_write;
        for (m = 3; m >= 2; m--) begin
            host.set_mode(m[1:0]);
            n = rx_cnt;
            host.par_wr(1'b0, 1'b1, 8'hA5);
            check({7'h00, dc_last, rx_last}, 16'h01A5);
            host.par_wr(1'b0, 1'b0, 8'h3C);
            check({7'h00, dc_last, rx_last}, 16'h003C);
            host.par_wr(1'b1, 1'b1, 8'h99);
            check(16'(rx_cnt - n), 16'h0002);
        end
    endtask
    task t_par_read;
        for (m = 3; m >= 2; m--) begin
            host.set_mode(m[1:0]);
            rd_data <= {4'h5, m[3:0]};
            n = rd_cnt;
            host.par_rd(q);
            check({8'h00, q}, {12'h005, m[3:0]});
            check(16'(rd_cnt - n), 16'h0001);
            check({8'h00, host_data_oe}, 16'h0000);
        end
    endtask
    task t_serial;
        host.set_mode(`DHI_MODE_SERIAL);
        host.ser(1'b1, 8'hB2, 8, 1'b0);
        check({7'h00, dc_last, rx_last}, 16'h01B2);
        host.ser(1'b0, 8'h4D, 8, 1'b0);
        check({7'h00, dc_last, rx_last}, 16'h004D);
        n = drop_cnt;
        host.ser(1'b1, 8'hFF, 3, 1'b0);
        check(16'(drop_cnt - n), 16'h0001);
        host.ser(1'b1, 8'hFF, 3, 1'b1);
        host.pulse_init;
        n = rx_cnt;
        host.ser(1'b1, 8'h81, 8, 1'b0);
        check({8'(rx_cnt - n), rx_last}, 16'h0181);
    endtask
    task t_i2c;
        host.set_mode(`DHI_MODE_I2C);
        host.i2c_start(1'b1);
        host.i2c_byte({`DHI_I2C_ADDR_HI, 2'h2}, ack);
        check({15'h0000, ack}, 16'h0001);
        host.i2c_byte(8'h80, ack);
        host.i2c_byte(8'h5A, ack);
        check({7'h00, dc_last, rx_last}, 16'h005A);
        host.i2c_byte(8'h40, ack);
        host.i2c_byte(8'hE7, ack);
        host.i2c_stop;
        check({6'h00, ack, dc_last, rx_last}, 16'h03E7);
        host.i2c_start(1'b0);
        host.i2c_byte({`DHI_I2C_ADDR_HI, 2'h2}, ack);
        host.i2c_stop;
        check({15'h0000, ack}, 16'h0000);
        host.i2c_start(1'b1);
        host.i2c_byte({`DHI_I2C_ADDR_HI, 2'h3}, ack);
        host.i2c_stop;
        check({15'h0000, ack}, 16'h0000);
    endtask
    initial begin
        num_errors = 0;
        samples_checked = 0;
        rx_cnt = 0;
        drop_cnt = 0;
        rd_cnt = 0;
        rstn = 1'b0;
        rd_data = 8'h00;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_par_write;
        t_par_read;
        t_serial;
        t_i2c;
        wrap_up;
    end
    initial begin
        #2000000;
        num_errors++;
        wrap_up;
    end
endmodule
